// File: pdmacq_cic.sv
// Third-order decimating filter turning one pulse-density stream into PCM.
`timescale 1ns/1ps
`default_nettype none
module pdmacq_cic
	import pdmacq_pkg::*;
(
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             clear,
	// Pulse-density input.
	input  wire logic             in_valid,
	input  wire logic             in_bit,
	// PCM output.
	output logic [PCM_W-1:0]      pcm_reg,
	output logic                  pcm_valid_reg
);

	logic signed [CIC_W-1:0] integ_reg [3];
	logic signed [CIC_W-1:0] integ_next [3];
	logic signed [CIC_W-1:0] dly_reg [3];
	logic signed [CIC_W-1:0] dly_next [3];
	logic [DEC_W-1:0]        dec_reg;
	logic [DEC_W-1:0]        dec_next;
	logic [PCM_W-1:0]        pcm_next;
	logic                    pcm_valid_next;

	////////////////////////////////////////////////////////////////////////////////
	// Integrators run at the bit rate, combs at the decimated rate.
	// The register width carries the full gain of 64 cubed, so the comb output is exact even though the integrators wrap.
	// Clearing also zeroes the output, so an idle microphone reads as silence in a frame.
	always_comb
	begin
		logic signed [CIC_W-1:0] stage;
		stage          = '0;
		integ_next     = integ_reg;
		dly_next       = dly_reg;
		dec_next       = dec_reg;
		pcm_next       = pcm_reg;
		pcm_valid_next = 1'b0;
		if (clear)
		begin
			for (int i = 0; i < 3; i++)
			begin
				integ_next[i] = '0;
				dly_next[i]   = '0;
			end
			dec_next = DEC_RST;
			pcm_next = '0;
		end
		else if (in_valid)
		begin
			integ_next[0] = integ_reg[0] + (in_bit ? CIC_W'(1) : -CIC_W'(1));
			integ_next[1] = integ_reg[1] + integ_next[0];
			integ_next[2] = integ_reg[2] + integ_next[1];
			dec_next      = dec_reg + 6'h01;
			if (dec_reg == DEC_LAST)
			begin
				stage = integ_next[2];
				for (int i = 0; i < 3; i++)
				begin
					dly_next[i] = stage;
					stage       = stage - dly_reg[i];
				end
				pcm_next       = stage[CIC_W-1:PCM_LSB];
				pcm_valid_next = 1'b1;
			end
		end
	end

	// Registers of the filter.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			for (int i = 0; i < 3; i++)
			begin
				integ_reg[i] <= '0;
				dly_reg[i]   <= '0;
			end
			dec_reg       <= DEC_RST;
			pcm_reg       <= '0;
			pcm_valid_reg <= 1'b0;
		end
		else
		begin
			integ_reg     <= integ_next;
			dly_reg       <= dly_next;
			dec_reg       <= dec_next;
			pcm_reg       <= pcm_next;
			pcm_valid_reg <= pcm_valid_next;
		end
	end

endmodule // pdmacq_cic
`default_nettype wire

// File: pdmacq_mic_model.sv
// Behavioural model of four pulse-density microphones on two shared lines.
`timescale 1ns/1ps
`default_nettype none
module pdmacq_mic_model
(
	// Clock from the block and test controls.
	input  wire logic       mic_clk,
	input  wire logic       solo,
	input  wire logic [3:0] level,
	// Shared data lines.
	output logic      [1:0] pdm_data
);
	// The rising-edge microphone drives in the low half so its bit is valid at the rise.
	// A solo microphone leaves line one unowned, so it shows a toggling pattern.
	always_comb
	begin
		if (solo)
			pdm_data = {mic_clk, level[0]};
		else if (mic_clk)
			pdm_data = {level[3], level[1]};
		else
			pdm_data = {level[2], level[0]};
	end
endmodule // pdmacq_mic_model
`default_nettype wire

// File: pdmacq_pkg.sv
// Package with constants and types of the PDM microphone acquisition block.
package pdmacq_pkg;

	// Structure sizes.
	localparam int NUM_LINES = 2;
	localparam int NUM_MICS  = 4;
	localparam int PCM_W     = 16;

	// Clock timing: half period of the master bit clock.
	localparam int CLK_PERIOD_NS = 4;
	localparam int BIT_HALF_NS   = 160;
	localparam int BIT_HALF_CYC  = (BIT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DIV_W         = 8;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BIT_HALF_CYC - 1);
	localparam logic [DIV_W-1:0] DIV_RST  = 8'h00;

	// Decimation filter: third order, decimation by 64.
	localparam int CIC_W   = 20;
	localparam int DEC_W   = 6;
	localparam logic [DEC_W-1:0] DEC_LAST = 6'h3f;
	localparam logic [DEC_W-1:0] DEC_RST  = 6'h00;
	localparam int PCM_LSB = CIC_W - PCM_W;

	// Acquisition modes.
	typedef enum logic [1:0] {
		PDMACQ_MODE_SDF,
		PDMACQ_MODE_SERIAL,
		PDMACQ_MODE_SINGLE
	} pdmacq_mode_e;

	// One PCM sample per microphone plus the mask of microphones in use.
	typedef struct packed {
		logic [NUM_MICS-1:0][PCM_W-1:0] pcm;
		logic [NUM_MICS-1:0]            active;
	} pdmacq_frame_s;

	// Bits of one microphone clock period, split per microphone.
	typedef struct packed {
		logic [NUM_MICS-1:0] bits;
		logic [NUM_MICS-1:0] valid;
	} pdmacq_bits_s;

endpackage

// File: pdmacq_sva.sv
// Port assertions for the PDM microphone acquisition top.
`timescale 1ns/1ps
`default_nettype none
module pdmacq_sva
	import pdmacq_pkg::*;
(
	// Clock, reset and configuration.
	input wire logic                 clk,
	input wire logic                 rst,
	input wire logic                 enable,
	input wire pdmacq_mode_e         mode,
	input wire logic [NUM_LINES-1:0] line_en,
	// Outputs and acknowledge.
	input wire logic                 mic_clk_reg,
	input wire logic                 bit_clk_reg,
	input wire pdmacq_frame_s        frame_reg,
	input wire logic                 dma_req_reg,
	input wire logic                 dma_ack,
	input wire logic                 overrun_reg
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic en_q;
	logic run;
	// Delayed enable, so the first cycle of a run is left out of the clock checks.
	always_ff @(posedge clk)
		en_q <= enable;
	assign run = enable && en_q;
	////////////////////////////////////////////////////////////
	// One bit clock edge followed by one whole half period.
	sequence s_half;
		$changed(bit_clk_reg) ##40 1'b1;
	endsequence
	a_bit_half: assert property (enable throughout s_half |-> $changed(bit_clk_reg))
		else $error("bit clock half period wrong");
	a_mic_divide: assert property (run && mode != PDMACQ_MODE_SINGLE
		|-> $changed(mic_clk_reg) == $rose(bit_clk_reg)) else $error("mic clock not halved");
	a_single_same: assert property (run && mode == PDMACQ_MODE_SINGLE
		|-> mic_clk_reg == bit_clk_reg) else $error("single mic clock differs");
	a_idle_low: assert property (!enable && !en_q |-> !bit_clk_reg && !mic_clk_reg)
		else $error("clocks run while disabled");
	a_req_drop: assert property (dma_req_reg && dma_ack |=> !dma_req_reg || $changed(frame_reg))
		else $error("request kept after ack");
	a_req_hold: assert property (dma_req_reg && !dma_ack |=> dma_req_reg)
		else $error("request lost without ack");
	a_frame_req: assert property ($changed(frame_reg) |-> dma_req_reg)
		else $error("frame changed without request");
	a_active_mask: assert property ($changed(frame_reg) |-> frame_reg.active ==
		(mode == PDMACQ_MODE_SINGLE ? 4'h1 : {{2{line_en[1]}}, {2{line_en[0]}}}))
		else $error("active mask wrong");
	a_ovr_cause: assert property ($rose(overrun_reg) |-> $past(dma_req_reg))
		else $error("overrun without pending frame");
	a_ovr_sticky: assert property (overrun_reg && enable |=> overrun_reg)
		else $error("overrun cleared while enabled");
endmodule // pdmacq_sva
`default_nettype wire

// File: pdmacq_tb_top.sv
// Self-checking bench for the PDM microphone acquisition top.
`timescale 1ns/1ps
`default_nettype none
module pdmacq_tb_top;
	import pdmacq_pkg::*;
	typedef struct packed {pdmacq_mode_e md; logic [1:0] len; logic [3:0] act;} pdmacq_row_s;
	// Mics 0 and 2 send all ones, mics 1 and 3 all zeros.
	localparam logic [3:0] LVL = 4'h5;
	logic          clk = 1'b0, rst = 1'b1, enable = 1'b0, dma_ack = 1'b0;
	pdmacq_mode_e  mode = PDMACQ_MODE_SDF;
	logic [1:0]    line_en = 2'h3;
	logic [1:0]    pdm_data;
	logic          mic_clk_reg, bit_clk_reg, dma_req_reg, overrun_reg;
	pdmacq_frame_s frame_reg;
	int            n_errors = 0, samples_checked = 0, cycles = 0;
	pdmacq_row_s   rows [3] = '{'{PDMACQ_MODE_SDF, 2'h3, 4'hf},
		'{PDMACQ_MODE_SERIAL, 2'h2, 4'hc}, '{PDMACQ_MODE_SINGLE, 2'h3, 4'h1}};
	always #2 clk = ~clk;
	pdmacq_top dut_u (.clk(clk), .rst(rst), .enable(enable), .mode(mode), .line_en(line_en),
		.pdm_data(pdm_data), .mic_clk_reg(mic_clk_reg), .bit_clk_reg(bit_clk_reg),
		.frame_reg(frame_reg), .dma_req_reg(dma_req_reg), .dma_ack(dma_ack),
		.overrun_reg(overrun_reg));
	pdmacq_mic_model mic_u (.mic_clk(mic_clk_reg), .solo(mode == PDMACQ_MODE_SINGLE),
		.level(LVL), .pdm_data(pdm_data));
	////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Bounded wait for the request (sel 0) or the overrun flag (sel 1).
	task automatic wait_hi(input int sel);
		int i;
		i = 0;
		while ((sel ? overrun_reg : dma_req_reg) !== 1'b1 && i < 20000)
		begin
			@(posedge clk);
			#1;
			i++;
		end
		check("wait flag", 16'h1, {15'h0, sel ? overrun_reg : dma_req_reg});
	endtask
	// Ack pulse of one cycle; the request must be gone at the next edge.
	task automatic ack();
		@(posedge clk);
		dma_ack <= 1'b1;
		@(posedge clk);
		dma_ack <= 1'b0;
		#1;
		check("req after ack", 16'h0, {15'h0, dma_req_reg});
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Hang guard: well above the roughly 72000 cycles the sequence needs.
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 100000)
		begin
			n_errors++;
			end_sim();
		end
	end
	////////////////////////////////////////////////////////////
	// Rows, then overrun, disable and mid-run reset.
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		#1;
		check("idle outs", 16'h0, {12'h0, mic_clk_reg, bit_clk_reg, dma_req_reg, overrun_reg});
		foreach (rows[r])
		begin
			repeat (2) @(posedge clk);
			mode <= rows[r].md;
			line_en <= rows[r].len;
			enable <= 1'b1;
			wait_hi(0);
			check("active", {12'h0, rows[r].act}, {12'h0, frame_reg.active});
			ack();
			// Second frame is still in the filter start-up transient, but its sign has settled.
			wait_hi(0);
			for (int i = 0; i < 4; i++)
				if (rows[r].act[i])
					check("pcm sign", {15'h0, ~LVL[i]}, {15'h0, frame_reg.pcm[i][15]});
				else
					check("pcm idle", 16'h0, frame_reg.pcm[i]);
			ack();
			@(posedge clk);
			enable <= 1'b0;
		end
		repeat (2) @(posedge clk);
		mode <= PDMACQ_MODE_SDF;
		line_en <= 2'h3;
		enable <= 1'b1;
		wait_hi(0);
		wait_hi(1);
		check("req kept", 16'h1, {15'h0, dma_req_reg});
		ack();
		@(posedge clk);
		enable <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check("disabled", 16'h0, {13'h0, mic_clk_reg, bit_clk_reg, overrun_reg});
		@(posedge clk);
		enable <= 1'b1;
		repeat (60) @(posedge clk);
		#1;
		check("clocks up", 16'h3, {14'h0, mic_clk_reg, bit_clk_reg});
		// Mid-run reset with enable high; the clocks must restart from a full half period.
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check("reset outs", 16'h0,
			{8'h0, frame_reg.active, mic_clk_reg, bit_clk_reg, dma_req_reg, overrun_reg});
		@(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check("after reset", 16'h0, {14'h0, mic_clk_reg, bit_clk_reg});
		repeat (45) @(posedge clk);
		#1;
		check("clocks restart", 16'h3, {14'h0, mic_clk_reg, bit_clk_reg});
		end_sim();
	end
endmodule // pdmacq_tb_top
bind pdmacq_top pdmacq_sva chk_u (.clk(clk), .rst(rst), .enable(enable), .mode(mode),
	.line_en(line_en), .mic_clk_reg(mic_clk_reg), .bit_clk_reg(bit_clk_reg),
	.frame_reg(frame_reg), .dma_req_reg(dma_req_reg), .dma_ack(dma_ack),
	.overrun_reg(overrun_reg));
`default_nettype wire

// File: pdmacq_top.sv
// Top of the PDM microphone acquisition block: clocks, edge capture, split, filters and DMA hand-off.
`timescale 1ns/1ps
`default_nettype none
module pdmacq_top
	import pdmacq_pkg::*;
(
	// Clock and reset.
	input  wire logic                 clk,
	input  wire logic                 rst,
	// Static configuration from the host.
	input  wire logic                 enable,
	input  wire pdmacq_mode_e         mode,
	input  wire logic [NUM_LINES-1:0] line_en,
	// Microphone pins.
	input  wire logic [NUM_LINES-1:0] pdm_data,
	output logic                      mic_clk_reg,
	output logic                      bit_clk_reg,
	// DMA hand-off.
	output pdmacq_frame_s             frame_reg,
	output logic                      dma_req_reg,
	input  wire logic                 dma_ack,
	output logic                      overrun_reg
);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser: the first stage is read only by the second.
	logic [NUM_LINES-1:0] data_meta_reg;
	logic [NUM_LINES-1:0] data_sync_reg;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			data_meta_reg <= '0;
			data_sync_reg <= '0;
		end
		else
		begin
			data_meta_reg <= pdm_data;
			data_sync_reg <= data_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Clock generation. The bit clock toggles every BIT_HALF_CYC cycles; the
	// microphone clock is the bit clock halved, except in single-mic mode where
	// the bit clock itself drives the microphone.
	logic [DIV_W-1:0] div_reg;
	logic [DIV_W-1:0] div_next;
	logic             bit_clk_next;
	logic             mic_clk_next;
	logic             tick;

	always_comb
	begin
		tick         = enable && (div_reg == DIV_LAST);
		div_next     = (!enable || tick) ? DIV_RST : div_reg + 8'h01;
		bit_clk_next = enable ? (bit_clk_reg ^ tick) : 1'b0;
		mic_clk_next = mic_clk_reg;
		if (!enable)
			mic_clk_next = 1'b0;
		else if (mode == PDMACQ_MODE_SINGLE)
			mic_clk_next = bit_clk_next;
		else if (tick && !bit_clk_reg)
			mic_clk_next = ~mic_clk_reg;
	end

	// Clock registers drive the pins directly, so both clocks are glitch free.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			div_reg     <= DIV_RST;
			bit_clk_reg <= 1'b0;
			mic_clk_reg <= 1'b0;
		end
		else
		begin
			div_reg     <= div_next;
			bit_clk_reg <= bit_clk_next;
			mic_clk_reg <= mic_clk_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Edge capture and split. Outside single-mic mode one bit is taken per line at every microphone
	// clock edge, which is one bit per bit-clock rising edge in serial mode; single-mic mode takes line 0 at the rise only.
	// Line 0 carries mics 0 and 1, line 1 carries mics 2 and 3; the even mic of a
	// pair is the rising-edge one. Rising bits are held until the falling bit of
	// the same period arrives, so the pair leaves together and stays aligned.
	logic                 mic_rise;
	logic                 mic_fall;
	logic [NUM_LINES-1:0] rise_bits_reg;
	logic [NUM_LINES-1:0] rise_bits_next;
	logic [NUM_MICS-1:0]  active;
	pdmacq_bits_s         split_reg;
	pdmacq_bits_s         split_next;

	always_comb
	begin
		mic_rise       = mic_clk_next && !mic_clk_reg;
		mic_fall       = !mic_clk_next && mic_clk_reg;
		rise_bits_next = mic_rise ? data_sync_reg : rise_bits_reg;
		split_next     = '0;
		if (mode == PDMACQ_MODE_SINGLE)
			active = {{(NUM_MICS-1){1'b0}}, 1'b1};
		else
			active = {{2{line_en[1]}}, {2{line_en[0]}}};
		if (mode == PDMACQ_MODE_SINGLE)
		begin
			split_next.bits[0]  = data_sync_reg[0];
			split_next.valid[0] = mic_rise;
		end
		else if (mic_fall)
		begin
			for (int l = 0; l < NUM_LINES; l++)
			begin
				split_next.bits[2*l]    = rise_bits_reg[l];
				split_next.bits[2*l+1]  = data_sync_reg[l];
				split_next.valid[2*l]   = active[2*l];
				split_next.valid[2*l+1] = active[2*l+1];
			end
		end
	end

	// Registers of the capture stage.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rise_bits_reg <= '0;
			split_reg     <= '0;
		end
		else
		begin
			rise_bits_reg <= rise_bits_next;
			split_reg     <= split_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// One decimation filter per microphone. All active filters see their bits in the same
	// cycle, so their outputs appear together and share one frame.
	logic [NUM_MICS-1:0][PCM_W-1:0] pcm;
	logic [NUM_MICS-1:0]            pcm_valid;

	genvar m;
	generate
		for (m = 0; m < NUM_MICS; m++)
		begin : g_mic
			pdmacq_cic u_cic (
				.clk           (clk),
				.rst           (rst),
				.clear         (!enable || !active[m]),
				.in_valid      (split_reg.valid[m]),
				.in_bit        (split_reg.bits[m]),
				.pcm_reg       (pcm[m]),
				.pcm_valid_reg (pcm_valid[m])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// DMA hand-off. A frame is offered with a request that stands until acknowledged.
	// A new frame while one is pending replaces it and sets the sticky overrun
	// flag; replacing keeps the newest audio, at the cost of a lost frame.
	logic          new_frame;
	logic          dma_req_next;
	logic          overrun_next;
	pdmacq_frame_s frame_next;

	always_comb
	begin
		new_frame    = |(pcm_valid & active);
		frame_next   = frame_reg;
		dma_req_next = dma_req_reg && !dma_ack;
		overrun_next = overrun_reg && enable;
		if (new_frame)
		begin
			frame_next.pcm    = pcm;
			frame_next.active = active;
			dma_req_next      = 1'b1;
			if (dma_req_reg && !dma_ack)
				overrun_next = 1'b1;
		end
	end

	// Registers of the hand-off.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			frame_reg   <= '0;
			dma_req_reg <= 1'b0;
			overrun_reg <= 1'b0;
		end
		else
		begin
			frame_reg   <= frame_next;
			dma_req_reg <= dma_req_next;
			overrun_reg <= overrun_next;
		end
	end

endmodule // pdmacq_top
`default_nettype wire
